// >>> bench/serial_station.sv
`timescale 1ns/10ps

module serial_station
(
  input wire logic hclk,
  input wire logic rx_baud_tick,
  output logic line_out
);
  initial line_out = 1'b1;

  // Bits leave LSB first, sixteen receive ticks each; the line keeps the last bit sent, mark or space, until the next send
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n * 16; i++)
    begin
      @(posedge hclk);
      while (rx_baud_tick !== 1'b1)
        @(posedge hclk);
      line_out <= bits[i / 16];
    end
  endtask : send
endmodule : serial_station

// >>> bench/testbench.sv
`timescale 1ns/10ps

module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic rx_baud_tick = 1'b0;
  logic tx_baud_tick = 1'b0;
  logic [31:0] hrdata, r;
  logic hreadyout, hresp, chan_b_serial_in, chan_b_serial_out, tx_holding_ready_flag, tx_empty_flag, rx_char_ready;
  logic prev = 1'b1;
  logic samp = 1'b1;
  logic echo_d = 1'b1;
  logic echo_on = 1'b0;
  logic [7:0] d;
  logic [5:0] stops[7] = '{6'h30, 6'h37, 6'h38, 6'h3f, 6'h00, 6'h07, 6'h09};
  int failures = 0;
  int comparisons = 0;
  int seed = 32'h3006e092;
  int cyc = 0;
  int txt = 0;
  int falls[$];
  int mreg[3] = '{0, 0, 0};
  int ptr = 0;
  int c, l;

  uart_chan_mode u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_baud_tick, .tx_baud_tick, .chan_b_serial_in,
    .chan_b_serial_out, .tx_holding_ready_flag, .tx_empty_flag, .rx_char_ready);
  serial_station u_station (.hclk, .rx_baud_tick, .line_out(chan_b_serial_in));

  always #25 hclk = ~hclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Receive ticks every third cycle, transmit every second, so the two clocks coincide only every sixth cycle
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    rx_baud_tick <= (cyc % 3 == 0);
    tx_baud_tick <= (cyc % 2 == 0);
    if (tx_baud_tick)
      txt++;
    if (prev && !chan_b_serial_out)
      falls.push_back(txt);
    prev = chan_b_serial_out;
    if (rx_baud_tick)
      samp <= chan_b_serial_in;
    echo_d <= samp;
    if (echo_on)
      chk({31'h0, chan_b_serial_out}, {31'h0, echo_d});
  end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    int e;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    e = mreg[ptr];
    if (a == 8'h08 && wr)
      mreg[ptr] = (ptr == 0) ? (wd & 8'hf8) : wd;
    if (a == 8'h08 && !wr)
      chk(r, 32'(e));
    if (a == 8'h08)
      ptr = (ptr < 2) ? ptr + 1 : 2;
    if (a == 8'h00 && wr && wd[4])
      ptr = 0;
  endtask : bus

  task automatic setup(input logic [7:0] one, input logic [7:0] two, input logic [7:0] cmd);
    bus(1'b1, 8'h00, cmd | 8'h10);
    bus(1'b1, 8'h08, 8'h00);
    bus(1'b1, 8'h08, one);
    bus(1'b1, 8'h08, two);
    bus(1'b1, 8'h00, cmd);
  endtask : setup

  task automatic stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Whole run needs under 20000 cycles; 60000 leaves room for slow receive framing
  initial
  begin
    #3000000;
    failures++;
    stop_test;
  end

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 8'h04, 8'h0);
    chk(r, 32'h0c);
    repeat (3) bus(1'b0, 8'h08, 8'h0);
    bus(1'b0, 8'h40, 8'h0);
    chk(r, 32'h0);
    bus(1'b1, 8'h00, 8'h10);
    repeat (4) bus(1'b1, 8'h08, 8'($random(seed)));
    bus(1'b1, 8'h00, 8'h10);
    repeat (4) bus(1'b0, 8'h08, 8'h0);
    $display("test registers done");
    foreach (stops[i])
    begin
      l = stops[i][5:4];
      c = stops[i][3:0];
      setup({3'h0, 2'h2, 1'b0, stops[i][5:4]}, {4'h0, stops[i][3:0]}, 8'h02);
      falls.delete();
      repeat (3)
      begin
        while (tx_holding_ready_flag !== 1'b1)
          @(posedge hclk);
        bus(1'b1, 8'h0c, 8'hff);
        repeat (3) @(posedge hclk);
      end
      while (tx_empty_flag !== 1'b1)
        @(posedge hclk);
      chk(32'(falls[2] - falls[1]), 32'(16 * (6 + l) + ((c < 8) ? 9 + c + ((l == 0) ? 8 : 0) : 17 + c)));
    end
    $display("test stop length done");
    d = 8'($random(seed));
    setup(8'h03, 8'h47, 8'h01);
    repeat (4) @(posedge hclk);
    echo_on <= 1'b1;
    bus(1'b1, 8'h0c, 8'h55);
    bus(1'b0, 8'h04, 8'h0);
    chk(r, 32'h0);
    u_station.send({2'h3, ~^d, d, 1'b0}, 12);
    repeat (4) @(posedge hclk);
    bus(1'b0, 8'h04, 8'h0);
    chk(r, 32'h21);
    bus(1'b0, 8'h0c, 8'h0);
    chk(r, {24'h0, d});
    $display("test echo done");
    d = d | 8'h01;
    setup(8'h03, 8'hc7, 8'h01);
    u_station.send({2'h2, ~^d, d, 1'b0}, 12);
    repeat (4) @(posedge hclk);
    bus(1'b0, 8'h04, 8'h0);
    chk(r, 32'h0c);
    echo_on <= 1'b0;
    u_station.send(12'h000, 11);
    u_station.send(12'hfff, 4);
    chk({31'h0, chan_b_serial_out}, 32'h0);
    u_station.send({2'h3, ^d, d, 1'b0}, 12);
    repeat (8) @(posedge hclk);
    chk({31'h0, chan_b_serial_out}, 32'h1);
    $display("test remote done");
    d = 8'($random(seed));
    setup(8'h07, 8'h80, 8'h02);
    fork
      u_station.send(12'h5a5, 12);
    join_none
    bus(1'b1, 8'h0c, d);
    while (rx_char_ready !== 1'b1)
      @(posedge hclk);
    bus(1'b0, 8'h0c, 8'h0);
    chk(r, {24'h0, d});
    wait fork;
    $display("test local done");
    stop_test;
  end
endmodule : testbench

// >>> bench/uart_chan_mode_asserts.sv
`timescale 1ns/10ps
`include "uart_chan_regs.svh"

module uart_chan_mode_asserts
  import uart_chan_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  input wire logic chan_b_serial_in,
  input wire logic chan_b_serial_out,
  input wire logic tx_holding_ready_flag,
  input wire logic tx_empty_flag,
  input wire logic rx_char_ready
);
  chan_mode_t mode_q;
  mode_ptr_t ptr_q;
  logic act_q;
  logic wr_q;
  logic [7:0] adr_q;
  wire take = hsel && htrans[1] && hready;
  wire mode_done = hready && act_q && adr_q == `ADDR_MODE;
  wire set_ptr = hready && act_q && wr_q && adr_q == `ADDR_COMMAND && hwdata[`CMD_SET_PTR];

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Shadow of pointer and channel mode, rebuilt from completed bus transfers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      act_q <= 1'b0;
      wr_q <= 1'b0;
      adr_q <= 8'h00;
      ptr_q <= PTR_ZERO;
      mode_q <= MODE_NORMAL;
    end
    else
    begin
      act_q <= take ? (hsize == 3'h2 && haddr[31:8] == 24'h0) : (act_q && !hready);
      if (take)
      begin
        wr_q <= hwrite;
        adr_q <= haddr[7:0];
      end
      if (set_ptr)
        ptr_q <= PTR_ZERO;
      else if (mode_done)
        ptr_q <= (ptr_q == PTR_ZERO) ? PTR_ONE : PTR_TWO;
      if (mode_done && wr_q && ptr_q == PTR_TWO)
        mode_q <= chan_mode_t'(hwdata[7:6]);
    end
  end

  a_wait_one: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("data phase not exactly one wait state");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_echo_flags: assert property (
    mode_q == MODE_AUTO_ECHO && $past(mode_q) == MODE_AUTO_ECHO |-> !tx_holding_ready_flag && !tx_empty_flag)
    else $error("transmit flags active in echo");
  a_local_high: assert property (
    mode_q == MODE_LOCAL_LOOP && $past(mode_q) == MODE_LOCAL_LOOP |-> chan_b_serial_out)
    else $error("serial out not high in local loop");
  a_remote_quiet: assert property (
    mode_q == MODE_REMOTE_LOOP && $past(mode_q) == MODE_REMOTE_LOOP |-> !$rose(rx_char_ready))
    else $error("character delivered in remote loop");
  a_reserved_zero: assert property (
    mode_done && !wr_q && ptr_q == PTR_ZERO |-> hrdata[2:0] == 3'h0)
    else $error("reserved bits of mode zero read nonzero");
  a_empty_ready: assert property (tx_empty_flag |-> tx_holding_ready_flag)
    else $error("empty without holding ready");
  a_idle_high: assert property (
    mode_q == MODE_NORMAL && $past(tx_empty_flag) && tx_empty_flag |-> chan_b_serial_out)
    else $error("idle transmitter line not high");

  c_write: cover property (take && hwrite);
  c_echo_char: cover property (mode_q == MODE_AUTO_ECHO && rx_char_ready);
  c_local_char: cover property (mode_q == MODE_LOCAL_LOOP && rx_char_ready);
endmodule : uart_chan_mode_asserts

bind uart_chan_mode uart_chan_mode_asserts u_chk
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .rx_baud_tick, .tx_baud_tick, .chan_b_serial_in, .chan_b_serial_out, .tx_holding_ready_flag,
  .tx_empty_flag, .rx_char_ready
);

// >>> rtl/serial_tx_unit.sv
`timescale 1ns/10ps
`include "uart_chan_regs.svh"

module serial_tx_unit
  import uart_chan_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic load,
  input wire logic [7:0] data,
  input wire logic [1:0] len_code,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic [5:0] stop_len,
  output logic line,
  output logic busy
);

  tx_state_t state_q;
  logic [5:0] cnt_q;
  logic [2:0] idx_q;
  logic [7:0] shreg_q;
  logic par_q;
  wire logic bit_end = tick && cnt_q[3:0] == `TICK_LAST;
  wire logic stop_end = tick && cnt_q == stop_len - 6'h01;

  assign busy = state_q != TX_IDLE;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= TX_IDLE;
      cnt_q <= 6'h00;
      idx_q <= 3'h0;
      shreg_q <= 8'h00;
      par_q <= 1'b0;
      line <= 1'b1;
    end
    else
    begin
      if (tick)
        cnt_q <= cnt_q + 6'h01;
      case (state_q)
        TX_IDLE:
        begin
          line <= 1'b1;
          cnt_q <= 6'h00;
          if (load)
          begin
            shreg_q <= data;
            par_q <= (^data) ^ par_odd;
            idx_q <= 3'h0;
            line <= 1'b0;
            state_q <= TX_START;
          end
        end
        TX_START:
          if (bit_end)
          begin
            cnt_q <= 6'h00;
            line <= shreg_q[0];
            state_q <= TX_DATA;
          end
        TX_DATA:
          if (bit_end)
          begin
            cnt_q <= 6'h00;
            if (idx_q == last_bit(len_code))
            begin
              line <= par_en ? par_q : 1'b1;
              state_q <= par_en ? TX_PARITY : TX_STOP;
            end
            else
            begin
              idx_q <= idx_q + 3'h1;
              shreg_q <= shreg_q >> 1;
              line <= shreg_q[1];
            end
          end
        TX_PARITY:
          if (bit_end)
          begin
            cnt_q <= 6'h00;
            line <= 1'b1;
            state_q <= TX_STOP;
          end
        TX_STOP:
          // Stop length counted in sixteenths of a bit
          if (stop_end)
            state_q <= TX_IDLE;
        default:
          state_q <= TX_IDLE;
      endcase
    end
  end

endmodule : serial_tx_unit

// >>> rtl/uart_chan_mode.sv
// Our own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`include "uart_chan_regs.svh"

module uart_chan_mode
  import uart_chan_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  input wire logic chan_b_serial_in,
  output logic chan_b_serial_out,
  output logic tx_holding_ready_flag,
  output logic tx_empty_flag,
  output logic rx_char_ready
);

  // Bus state
  logic pend_q;
  logic wr_q;
  logic [7:0] addr_q;
  logic addr_ok_q;

  // Registers
  logic [1:0] cmd_q;
  logic [7:0] mode_zero_q;
  logic [7:0] mode_one_q;
  logic [7:0] mode_two_q;
  mode_ptr_t ptr_q;
  logic [7:0] hold_q;
  logic hold_full_q;
  logic [7:0] rx_data_q;
  logic rx_ready_q;
  logic par_err_q;
  logic frame_err_q;
  logic brk_q;

  // Receiver state
  rx_state_t rx_state_q;
  logic [3:0] rx_cnt_q;
  logic [2:0] rx_idx_q;
  logic [7:0] rx_sh_q;
  logic rx_par_q;
  logic echo_bit_q;
  logic brk_hold_q;

  wire logic addr_phase = hsel && htrans[1] && hready;
  wire logic acc_now = pend_q;
  wire logic wr_now = acc_now && wr_q && addr_ok_q;
  wire logic rd_now = acc_now && !wr_q && addr_ok_q;
  wire logic mode_acc = acc_now && addr_ok_q && addr_q == `ADDR_MODE;
  wire logic cmd_wr = wr_now && addr_q == `ADDR_COMMAND;
  wire logic data_wr = wr_now && addr_q == `ADDR_DATA;
  wire logic data_rd = rd_now && addr_q == `ADDR_DATA;

  wire chan_mode_t chan_mode = chan_mode_t'(mode_two_q[`MODE_TWO_CHMODE_HI:`MODE_TWO_CHMODE_LO]);
  wire logic m_echo = chan_mode == MODE_AUTO_ECHO;
  wire logic m_local = chan_mode == MODE_LOCAL_LOOP;
  wire logic m_remote = chan_mode == MODE_REMOTE_LOOP;
  wire logic m_reflect = m_echo || m_remote;

  wire logic rx_en = cmd_q[`CMD_RX_EN];
  wire logic tx_en = cmd_q[`CMD_TX_EN];
  wire logic [1:0] len_code = mode_one_q[`MODE_ONE_LEN_HI:`MODE_ONE_LEN_LO];
  wire logic par_en = mode_one_q[`MODE_ONE_PAR_HI:`MODE_ONE_PAR_LO] == 2'h0;
  wire logic par_odd = mode_one_q[`MODE_ONE_ODD];
  wire logic [3:0] stop_code = mode_two_q[`MODE_TWO_STOP_HI:`MODE_TWO_STOP_LO];

  // Stop time in sixteenths of a bit
  wire logic stop_long = stop_code[3];
  wire logic [5:0] stop_base = stop_long ? `STOP_LONG_BASE : `STOP_SHORT_BASE;
  wire logic [5:0] stop_plain = stop_base + {3'h0, stop_code[2:0]};
  wire logic five_bit = len_code == 2'h0;
  wire logic [5:0] stop_extra = (five_bit && !stop_long) ? `STOP_FIVE_EXTRA : 6'h00;
  wire logic [5:0] stop_len = stop_plain + stop_extra;

  // Clock and data routing per mode
  wire logic tx_line;
  wire logic tx_busy;
  wire logic rx_tick = m_local ? tx_baud_tick : rx_baud_tick;
  wire logic tx_tick = m_reflect ? rx_baud_tick : tx_baud_tick;
  wire logic rx_line = m_local ? tx_line : chan_b_serial_in;
  // The receiver is needed in local loop even when left disabled
  wire logic rx_active = rx_en || m_local;
  wire logic tx_load = hold_full_q && tx_en && !tx_busy && !m_echo;

  // Receiver decode
  wire logic rx_bit_end = rx_tick && rx_cnt_q == `TICK_LAST;
  wire logic rx_mid = rx_tick && rx_cnt_q == `TICK_MID;
  wire logic start_valid = rx_state_q == RX_START && rx_mid && !rx_line;
  wire logic stop_done = rx_state_q == RX_STOP && rx_bit_end;
  wire logic [7:0] rx_char = (rx_sh_q >> (2'h3 - len_code)) & char_mask(len_code);
  wire logic par_bad = par_en && ((^rx_char) ^ rx_par_q) != par_odd;
  wire logic is_break = stop_done && !rx_line && rx_char == 8'h00 && !(par_en && rx_par_q);
  // Remote loop hands nothing to the host and checks nothing
  wire logic deliver = stop_done && !m_remote;
  wire logic chk_par = deliver && par_bad;
  wire logic chk_frame = deliver && !rx_line;

  wire logic [7:0] status_byte = {brk_q, frame_err_q, par_err_q, 1'b0, !hold_full_q && !tx_busy && !m_echo,
    !hold_full_q && !m_echo, 1'b0, rx_ready_q};

  wire logic [7:0] mode_rd = ptr_q == PTR_ZERO ? (mode_zero_q & `MODE_ZERO_RSVD_MASK) :
    ptr_q == PTR_ONE ? mode_one_q : mode_two_q;

  logic [7:0] rd_byte;
  assign rd_byte = !addr_ok_q ? 8'h00 :
    addr_q == `ADDR_COMMAND ? {6'h00, cmd_q} :
    addr_q == `ADDR_STATUS ? status_byte :
    addr_q == `ADDR_MODE ? mode_rd :
    addr_q == `ADDR_DATA ? rx_data_q : 8'h00;

  // One wait state per transfer so that read data comes from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      addr_ok_q <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      pend_q <= addr_phase;
      hreadyout <= !addr_phase;
      if (addr_phase)
      begin
        wr_q <= hwrite;
        addr_q <= haddr[7:0];
        addr_ok_q <= haddr[31:8] == 24'h000000 && haddr[1:0] == 2'h0 && hsize == 3'h2;
      end
      if (rd_now)
        hrdata <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cmd_q <= `CMD_RST;
    else if (cmd_wr)
      cmd_q <= hwdata[1:0];
  end

  // Mode registers share one address behind the pointer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_zero_q <= `MODE_ZERO_RST;
      mode_one_q <= `MODE_ONE_RST;
      mode_two_q <= `MODE_TWO_RST;
    end
    else if (mode_acc && wr_q)
    begin
      case (ptr_q)
        PTR_ZERO: mode_zero_q <= hwdata[7:0] & `MODE_ZERO_RSVD_MASK;
        PTR_ONE: mode_one_q <= hwdata[7:0];
        default: mode_two_q <= hwdata[7:0];
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ptr_q <= PTR_ZERO;
    else if (cmd_wr && hwdata[`CMD_SET_PTR])
      ptr_q <= PTR_ZERO;
    else if (mode_acc)
    begin
      case (ptr_q)
        PTR_ZERO: ptr_q <= PTR_ONE;
        PTR_ONE: ptr_q <= PTR_TWO;
        default: ptr_q <= PTR_TWO;
      endcase
    end
  end

  // Transmit holding register; writes while full or in echo are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
    end
    else if (tx_load)
      hold_full_q <= 1'b0;
    else if (data_wr && !hold_full_q && !m_echo)
    begin
      hold_q <= hwdata[7:0] & char_mask(len_code);
      hold_full_q <= 1'b1;
    end
  end

  serial_tx_unit u_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tx_tick),
    .load(tx_load),
    .data(hold_q),
    .len_code(len_code),
    .par_en(par_en),
    .par_odd(par_odd),
    .stop_len(stop_len),
    .line(tx_line),
    .busy(tx_busy)
  );

  // Receiver, 16x oversampled; samples at mid-bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_idx_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
    end
    else
    begin
      if (rx_tick)
        rx_cnt_q <= rx_cnt_q + 4'h1;
      case (rx_state_q)
        RX_IDLE:
        begin
          rx_cnt_q <= 4'h0;
          if (rx_active && rx_tick && !rx_line)
            rx_state_q <= RX_START;
        end
        RX_START:
          if (rx_mid)
          begin
            rx_cnt_q <= 4'h0;
            rx_idx_q <= 3'h0;
            rx_par_q <= 1'b0;
            rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_bit_end)
          begin
            rx_sh_q <= {rx_line, rx_sh_q[7:1]};
            rx_idx_q <= rx_idx_q + 3'h1;
            if (rx_idx_q == last_bit(len_code))
              rx_state_q <= par_en ? RX_PARITY : RX_STOP;
          end
        RX_PARITY:
          if (rx_bit_end)
          begin
            rx_par_q <= rx_line;
            rx_state_q <= RX_STOP;
          end
        RX_STOP:
          if (rx_bit_end)
            rx_state_q <= is_break ? RX_BREAK : RX_IDLE;
        RX_BREAK:
          // Wait for the line to return to mark before hunting again
          if (rx_tick && rx_line)
            rx_state_q <= RX_IDLE;
        default:
          rx_state_q <= RX_IDLE;
      endcase
      if (!rx_active)
        rx_state_q <= RX_IDLE;
    end
  end

  // Host-side receive status; a new character wins over a read clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_data_q <= 8'h00;
      rx_ready_q <= 1'b0;
      par_err_q <= 1'b0;
      frame_err_q <= 1'b0;
      brk_q <= 1'b0;
    end
    else if (deliver)
    begin
      rx_data_q <= rx_char;
      rx_ready_q <= 1'b1;
      par_err_q <= chk_par;
      frame_err_q <= chk_frame;
      brk_q <= is_break;
    end
    else if (data_rd || m_remote)
    begin
      rx_ready_q <= 1'b0;
      par_err_q <= 1'b0;
      frame_err_q <= 1'b0;
      brk_q <= 1'b0;
    end
  end

  // Reclock the raw line so parity and stop bits go back out unchanged
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      echo_bit_q <= 1'b1;
      brk_hold_q <= 1'b0;
    end
    else
    begin
      if (!rx_en)
        echo_bit_q <= 1'b1;
      else if (rx_tick)
        echo_bit_q <= rx_line;
      if (start_valid)
        brk_hold_q <= 1'b0;
      else if (is_break && m_reflect)
        brk_hold_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      chan_b_serial_out <= 1'b1;
      tx_holding_ready_flag <= 1'b0;
      tx_empty_flag <= 1'b0;
      rx_char_ready <= 1'b0;
    end
    else
    begin
      if (m_local)
        chan_b_serial_out <= 1'b1;
      else if (m_reflect)
        chan_b_serial_out <= echo_bit_q && !brk_hold_q;
      else
        chan_b_serial_out <= tx_line;
      tx_holding_ready_flag <= !hold_full_q && !m_echo;
      tx_empty_flag <= !hold_full_q && !tx_busy && !m_echo;
      rx_char_ready <= rx_ready_q;
    end
  end

endmodule : uart_chan_mode

// >>> rtl/uart_chan_pkg.sv
package uart_chan_pkg;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_AUTO_ECHO, MODE_LOCAL_LOOP, MODE_REMOTE_LOOP} chan_mode_t;
  typedef enum logic [1:0] {PTR_ZERO, PTR_ONE, PTR_TWO} mode_ptr_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK} rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;

  // Bits of a character of length code 0..3 (5..8 bits)
  function automatic logic [7:0] char_mask(input logic [1:0] len);
    char_mask = 8'hff >> (2'h3 - len);
  endfunction : char_mask

  // Index of the last data bit
  function automatic logic [2:0] last_bit(input logic [1:0] len);
    last_bit = {1'b0, len} + 3'h4;
  endfunction : last_bit

endpackage : uart_chan_pkg

// >>> rtl/uart_chan_regs.svh
`ifndef UART_CHAN_REGS_SVH
`define UART_CHAN_REGS_SVH

// Byte addresses, one aligned 32-bit word each
`define ADDR_COMMAND 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_MODE 8'h08
`define ADDR_DATA 8'h0c

// Command register fields
`define CMD_RX_EN 0
`define CMD_TX_EN 1
`define CMD_SET_PTR 4
`define CMD_RST 2'h0

// Mode register reset values and fields
`define MODE_ZERO_RST 8'h00
`define MODE_ONE_RST 8'h00
`define MODE_TWO_RST 8'h00
`define MODE_ZERO_RSVD_MASK 8'hf8
`define MODE_ONE_LEN_HI 1
`define MODE_ONE_LEN_LO 0
`define MODE_ONE_ODD 2
`define MODE_ONE_PAR_HI 4
`define MODE_ONE_PAR_LO 3
`define MODE_TWO_CHMODE_HI 7
`define MODE_TWO_CHMODE_LO 6
`define MODE_TWO_STOP_HI 3
`define MODE_TWO_STOP_LO 0

// Status register fields
`define ST_RX_READY 0
`define ST_TX_HOLD_READY 2
`define ST_TX_EMPTY 3
`define ST_PAR_ERR 5
`define ST_FRAME_ERR 6
`define ST_BREAK 7

// Timing in 16x baud ticks
`define TICK_LAST 4'hf
`define TICK_MID 4'h7
`define STOP_SHORT_BASE 6'h09
`define STOP_LONG_BASE 6'h19
`define STOP_FIVE_EXTRA 6'h08

`endif
